/* File: pprd_dsp.sv */
`timescale 1ns/1ps
`default_nettype none
module pprd_dsp (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_sample_valid,
    input  wire logic [23:0] i_v_sample,
    input  wire logic [23:0] i_i_sample,
    input  wire logic        i_wave_tick,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [15:0] o_reg_rdata,
    output logic             o_meas_irq,
    output logic      [23:0] o_v_comp,
    output logic      [23:0] o_i_comp,
    output logic             o_comp_valid,
    output logic      [23:0] o_wave_data,
    output logic             o_wave_valid,
    output logic      [23:0] o_vrms,
    output logic      [23:0] o_irms
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] voltage_peak_threshold;
    logic [15:0] current_peak_threshold;
    logic [15:0] voltage_max_record;
    logic [15:0] current_max_record;
    logic [7:0]  phase_delay_trim;
    logic [7:0]  waveform_source_select;
    logic [7:0]  measurement_irq_enable_3;
    logic [7:0]  measurement_irq_status_3;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire wr_vthr  = i_reg_wr && (i_reg_addr == pprd_pkg::ADDR_VPK_THR);
    wire wr_ithr  = i_reg_wr && (i_reg_addr == pprd_pkg::ADDR_IPK_THR);
    wire wr_trim  = i_reg_wr && (i_reg_addr == pprd_pkg::ADDR_TRIM);
    wire wr_wsel  = i_reg_wr && (i_reg_addr == pprd_pkg::ADDR_WAVE_SEL);
    wire wr_en3   = i_reg_wr && (i_reg_addr == pprd_pkg::ADDR_IRQ_EN3);
    wire wr_st3   = i_reg_wr && (i_reg_addr == pprd_pkg::ADDR_IRQ_ST3);
    wire rc_vmax  = i_reg_rd && (i_reg_addr == pprd_pkg::ADDR_VMAX_RC);
    wire rc_imax  = i_reg_rd && (i_reg_addr == pprd_pkg::ADDR_IMAX_RC);

    logic [15:0] rd_mux;
    always_comb begin
        case (i_reg_addr)
            pprd_pkg::ADDR_VPK_THR:  rd_mux = voltage_peak_threshold;
            pprd_pkg::ADDR_IPK_THR:  rd_mux = current_peak_threshold;
            pprd_pkg::ADDR_VMAX,
            pprd_pkg::ADDR_VMAX_RC:  rd_mux = voltage_max_record;
            pprd_pkg::ADDR_IMAX,
            pprd_pkg::ADDR_IMAX_RC:  rd_mux = current_max_record;
            pprd_pkg::ADDR_TRIM:     rd_mux = {8'h00, phase_delay_trim};
            pprd_pkg::ADDR_WAVE_SEL: rd_mux = {8'h00, waveform_source_select};
            pprd_pkg::ADDR_IRQ_EN3:  rd_mux = {8'h00, measurement_irq_enable_3};
            pprd_pkg::ADDR_IRQ_ST3:  rd_mux = {8'h00, measurement_irq_status_3};
            default:                 rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // phase trim clamp: illegal codes are held at the nearest legal end
    // ----------------------------------------------------------------
    wire signed [7:0] trim_in  = i_reg_wdata[7:0];
    wire [7:0]        trim_lim = (trim_in < pprd_pkg::TRIM_MIN) ? pprd_pkg::TRIM_MIN :
                                 (trim_in > pprd_pkg::TRIM_MAX) ? pprd_pkg::TRIM_MAX :
                                 trim_in;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            voltage_peak_threshold   <= pprd_pkg::RST_PK_THR;
            current_peak_threshold   <= pprd_pkg::RST_PK_THR;
            phase_delay_trim         <= pprd_pkg::RST_TRIM;
            waveform_source_select   <= pprd_pkg::RST_WAVE_SEL;
            measurement_irq_enable_3 <= pprd_pkg::RST_IRQ;
        end else begin
            if (wr_vthr) voltage_peak_threshold <= i_reg_wdata;
            if (wr_ithr) current_peak_threshold <= i_reg_wdata;
            if (wr_trim) phase_delay_trim <= trim_lim;
            if (wr_wsel) waveform_source_select <= i_reg_wdata[7:0];
            if (wr_en3)  measurement_irq_enable_3 <= i_reg_wdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // peak detection on the top two bytes
    // ----------------------------------------------------------------
    wire signed [15:0] v_hi  = i_v_sample[23:8];
    wire signed [15:0] i_hi  = i_i_sample[23:8];
    // 0x8000 negates to itself, which reads correctly as unsigned magnitude
    wire [15:0] v_abs = v_hi[15] ? 16'(-v_hi) : v_hi;
    wire [15:0] i_abs = i_hi[15] ? 16'(-i_hi) : i_hi;

    wire v_over = i_sample_valid && (v_abs > voltage_peak_threshold);
    wire i_over = i_sample_valid && (i_abs > current_peak_threshold);

    wire [7:0] peak_set = 8'(({7'h00, v_over} << pprd_pkg::BIT_PKV) |
                             ({7'h00, i_over} << pprd_pkg::BIT_PKI));
    // write-one-to-clear; a new peak in the same cycle survives the clear
    wire [7:0] peak_clr = wr_st3 ? (i_reg_wdata[7:0] & pprd_pkg::PEAK_MASK) : 8'h00;
    wire [7:0] next_status = ((measurement_irq_status_3 & ~peak_clr) | peak_set)
                             & pprd_pkg::PEAK_MASK;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            measurement_irq_status_3 <= pprd_pkg::RST_IRQ;
        end else begin
            measurement_irq_status_3 <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    // level output, held until the causing flag or its enable bit is cleared
    assign o_meas_irq = |(measurement_irq_status_3 & measurement_irq_enable_3
                          & pprd_pkg::PEAK_MASK);

    // ----------------------------------------------------------------
    // maximum records
    // ----------------------------------------------------------------
    wire v_grow = i_sample_valid && (v_abs > voltage_max_record);
    wire i_grow = i_sample_valid && (i_abs > current_max_record);

    // a clear read restarts from the sample of the same cycle, so none is lost
    wire [15:0] next_vmax = rc_vmax ? (i_sample_valid ? v_abs : 16'h0000) :
                            v_grow  ? v_abs : voltage_max_record;
    wire [15:0] next_imax = rc_imax ? (i_sample_valid ? i_abs : 16'h0000) :
                            i_grow  ? i_abs : current_max_record;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            voltage_max_record <= 16'h0000;
            current_max_record <= 16'h0000;
        end else begin
            voltage_max_record <= next_vmax;
            current_max_record <= next_imax;
        end
    end

    // ----------------------------------------------------------------
    // phase compensation delay line
    // ----------------------------------------------------------------
    // the current path sits at a fixed 190-sample delay so the voltage path can lead it
    logic [47:0] dly_mem [256];
    logic [7:0]  dly_wp;

    wire [7:0]  v_delay = 8'(phase_delay_trim - pprd_pkg::TRIM_MIN);
    wire [7:0]  v_rd    = 8'(dly_wp - v_delay);
    wire [7:0]  i_rd    = 8'(dly_wp - pprd_pkg::CUR_DELAY);
    wire [23:0] v_tap   = (v_delay == 8'h00) ? i_v_sample : dly_mem[v_rd][47:24];
    wire [23:0] i_tap   = dly_mem[i_rd][23:0];

    always_ff @(posedge i_clk_sys) begin
        if (i_sample_valid) begin
            dly_mem[dly_wp] <= {i_v_sample, i_i_sample};
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dly_wp       <= 8'h00;
            o_v_comp     <= 24'h000000;
            o_i_comp     <= 24'h000000;
            o_comp_valid <= 1'b0;
        end else begin
            o_comp_valid <= i_sample_valid;
            if (i_sample_valid) begin
                dly_wp   <= 8'(dly_wp + 8'h01);
                o_v_comp <= v_tap;
                o_i_comp <= i_tap;
            end
        end
    end

    // ----------------------------------------------------------------
    // rms: square, average, root; one lane per channel
    // ----------------------------------------------------------------
    logic signed [23:0]              ch_smp [2];
    logic        [pprd_pkg::ROOT_W-1:0] ch_rms [2];

    assign ch_smp[0] = i_v_sample;
    assign ch_smp[1] = i_i_sample;

    for (genvar ch = 0; ch < 2; ch++) begin : g_rms
        logic [47:0]           sq;
        logic [47:0]           acc;
        logic                  acc_upd;
        pprd_pkg::pprd_root_e  state;
        logic [55:0]           rad;
        logic [29:0]           rem;
        logic [pprd_pkg::ROOT_W-1:0] q;
        logic [4:0]            cnt;
        logic [29:0]           rem_sh;
        logic [29:0]           trial;
        logic                  ge;

        assign sq     = 48'(ch_smp[ch] * ch_smp[ch]);
        assign rem_sh = {rem[27:0], rad[55:54]};
        assign trial  = {q, 2'b01};
        assign ge     = (rem_sh >= trial);

        // first-order average, corner near 2 Hz at the nominal sample rate
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                acc     <= 48'h0;
                acc_upd <= 1'b0;
            end else begin
                acc_upd <= i_sample_valid;
                if (i_sample_valid) begin
                    acc <= 48'(acc + (sq >> pprd_pkg::LPF_SHIFT)
                               - (acc >> pprd_pkg::LPF_SHIFT));
                end
            end
        end

        // bit-serial root; an update landing while busy is skipped, which the slow
        // average makes harmless
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                state      <= pprd_pkg::ROOT_IDLE;
                rad        <= 56'h0;
                rem        <= 30'h0;
                q          <= '0;
                cnt        <= 5'h00;
                ch_rms[ch] <= '0;
            end else begin
                case (state)
                    pprd_pkg::ROOT_IDLE: begin
                        if (acc_upd) begin
                            rad   <= {acc, 8'h00} << 0;
                            rem   <= 30'h0;
                            q     <= '0;
                            cnt   <= pprd_pkg::ROOT_STEPS;
                            state <= pprd_pkg::ROOT_RUN;
                        end
                    end
                    pprd_pkg::ROOT_RUN: begin
                        rem <= ge ? 30'(rem_sh - trial) : rem_sh;
                        q   <= {q[pprd_pkg::ROOT_W-2:0], ge};
                        rad <= {rad[53:0], 2'b00};
                        cnt <= 5'(cnt - 5'h01);
                        if (cnt == 5'h00) begin
                            ch_rms[ch] <= {q[pprd_pkg::ROOT_W-2:0], ge};
                            state      <= pprd_pkg::ROOT_IDLE;
                        end
                    end
                    default: state <= pprd_pkg::ROOT_IDLE;
                endcase
            end
        end
    end

    // internal rms carries extra gain bits; outputs keep the low 24 only
    assign o_vrms = ch_rms[0][23:0];
    assign o_irms = ch_rms[1][23:0];

    // ----------------------------------------------------------------
    // waveform output of rms values
    // ----------------------------------------------------------------
    // the divider is cleared only by reset, so a rate change lands on an arbitrary phase
    logic [2:0] wave_div;
    wire  [1:0] wave_rate = waveform_source_select[4:3];
    wire  [2:0] wave_src  = waveform_source_select[2:0];
    wire  [2:0] rate_mask = 3'((4'h1 << wave_rate) - 4'h1);
    wire        wave_fire = i_wave_tick && ((wave_div & rate_mask) == 3'h0);
    wire        wave_on   = measurement_irq_enable_3[pprd_pkg::BIT_WAVEFORM_SAMPLE_ENABLE];
    wire        src_v     = (wave_src == pprd_pkg::WAVE_SRC_VRMS);
    wire        src_i     = (wave_src == pprd_pkg::WAVE_SRC_IRMS);
    wire        wave_go   = wave_fire && wave_on;
    wire        take_v    = wave_go && src_v;
    wire        take_i    = wave_go && src_i;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wave_div     <= 3'h0;
            o_wave_data  <= 24'h000000;
            o_wave_valid <= 1'b0;
        end else begin
            if (i_wave_tick) wave_div <= 3'(wave_div + 3'h1);
            o_wave_valid <= take_v || take_i;
            if (take_v) o_wave_data <= o_vrms;
            if (take_i) o_wave_data <= o_irms;
        end
    end

endmodule // pprd_dsp
`default_nettype wire

/* File: pprd_pkg.sv */
package pprd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_WAVE_SEL  = 8'h0D;
    localparam logic [7:0] ADDR_IRQ_EN3   = 8'hDB;
    localparam logic [7:0] ADDR_IRQ_ST3   = 8'hDE;
    localparam logic [7:0] ADDR_VPK_THR   = 8'h20;
    localparam logic [7:0] ADDR_IPK_THR   = 8'h21;
    localparam logic [7:0] ADDR_VMAX      = 8'h22;
    localparam logic [7:0] ADDR_IMAX      = 8'h23;
    localparam logic [7:0] ADDR_VMAX_RC   = 8'h24;
    localparam logic [7:0] ADDR_IMAX_RC   = 8'h25;
    localparam logic [7:0] ADDR_TRIM      = 8'h26;

    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int         BIT_PKV        = 4;
    localparam int         BIT_PKI        = 5;
    localparam int         BIT_WAVEFORM_SAMPLE_ENABLE       = 0;
    localparam logic [7:0] PEAK_MASK      = 8'h30;
    localparam logic [2:0] WAVE_SRC_VRMS  = 3'h6;
    localparam logic [2:0] WAVE_SRC_IRMS  = 3'h7;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_PK_THR    = 16'hFFFF;
    localparam logic [7:0]  RST_TRIM      = 8'h40;
    localparam logic [7:0]  RST_WAVE_SEL  = 8'h00;
    localparam logic [7:0]  RST_IRQ       = 8'h00;

    // ----------------------------------------------------------------
    // phase trim and rms figures
    // ----------------------------------------------------------------
    localparam logic signed [7:0] TRIM_MIN  = 8'sh82;
    localparam logic signed [7:0] TRIM_MAX  = 8'sh68;
    localparam logic [7:0]  CUR_DELAY       = 8'hBE;
    localparam int          LPF_SHIFT       = 16;
    localparam int          RMS_GAIN_SHIFT  = 4;
    localparam int          ROOT_W          = 28;
    localparam logic [4:0]  ROOT_STEPS      = 5'h1B;

    typedef enum logic {ROOT_IDLE, ROOT_RUN} pprd_root_e;

endpackage

/* File: pprd_dsp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pprd_dsp_monitor (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_sample_valid,
    input wire logic        i_wave_tick,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_meas_irq,
    input wire logic [23:0] o_v_comp,
    input wire logic [23:0] o_i_comp,
    input wire logic        o_comp_valid,
    input wire logic        o_wave_valid
);
    // ----------
    // sequences
    // ----------
    default clocking mon_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    // a sample in either cycle would refill the record
    sequence clear_then_read_s;
        i_reg_rd && !i_sample_valid && i_reg_addr == pprd_pkg::ADDR_VMAX_RC
        ##1 i_reg_rd && !i_sample_valid && i_reg_addr == pprd_pkg::ADDR_VMAX;
    endsequence
    sequence trim_over_s;
        i_reg_wr && i_reg_addr == pprd_pkg::ADDR_TRIM
        && $signed(i_reg_wdata[7:0]) > pprd_pkg::TRIM_MAX
        ##1 i_reg_rd && i_reg_addr == pprd_pkg::ADDR_TRIM;
    endsequence
    // ----------
    // assertions
    // ----------
    echo_pulse_a:
        assert property (i_sample_valid |=> o_comp_valid)
        else $error("no echo");
    comp_hold_a:
        assert property (!o_comp_valid |-> $stable(o_v_comp) && $stable(o_i_comp))
        else $error("data moved");
    irq_cause_a:
        assert property ($rose(o_meas_irq) |-> $past(i_sample_valid)
            || $past(i_reg_wr) && $past(i_reg_addr) == pprd_pkg::ADDR_IRQ_EN3)
        else $error("irq without cause");
    irq_hold_a:
        assert property ($fell(o_meas_irq) |-> $past(i_reg_wr)
            && ($past(i_reg_addr) == pprd_pkg::ADDR_IRQ_ST3
            || $past(i_reg_addr) == pprd_pkg::ADDR_IRQ_EN3))
        else $error("irq dropped");
    max_clear_a:
        assert property (clear_then_read_s |=> o_reg_rdata == 16'h0000)
        else $error("record kept");
    trim_clamp_a:
        assert property (trim_over_s |=> o_reg_rdata[7:0] == pprd_pkg::TRIM_MAX)
        else $error("trim not clamped");
    status_bits_a:
        assert property (i_reg_rd && i_reg_addr == pprd_pkg::ADDR_IRQ_ST3
            |=> (o_reg_rdata & ~16'h0030) == 16'h0000)
        else $error("stray status bit");
    wave_tick_a:
        assert property (o_wave_valid |-> $past(i_wave_tick))
        else $error("wave without tick");
endmodule // pprd_dsp_monitor
`default_nettype wire

/* File: pprd_sample_src.sv */
`timescale 1ns/1ps
`default_nettype none
module pprd_sample_src (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic        i_slow,
    input  wire logic [23:0] i_v,
    input  wire logic [23:0] i_i,
    output logic             o_ready,
    output var logic         o_valid,
    output var logic  [23:0] o_v,
    output var logic  [23:0] o_i
);
    logic [5:0] gap;
    assign o_ready = (gap == 6'h00);
    // lines toggle between samples so stale data never looks valid
    always @(negedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {o_valid, o_v, o_i, gap} <= '0;
        end else if (i_go && o_ready) begin
            o_valid <= 1'b1;
            o_v     <= i_v;
            o_i     <= i_i;
            gap     <= i_slow ? 6'h3C : 6'h21;
        end else begin
            o_valid <= 1'b0;
            o_v     <= ~o_v;
            o_i     <= ~o_i;
            gap     <= (gap == 6'h00) ? gap : gap - 6'h01;
        end
    end
endmodule // pprd_sample_src
`default_nettype wire

/* File: pprd_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_wave_tick = 1'b0;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic        i_sample_valid, rdy, o_meas_irq, o_comp_valid, o_wave_valid;
    logic [23:0] i_v_sample, i_i_sample, o_v_comp, o_i_comp, o_wave_data, o_vrms, o_irms;
    logic [15:0] o_reg_rdata;
    logic        go = 1'b0, slow = 1'b0, rd_d = 1'b0, wsrc = 1'b0;
    logic [23:0] sv = 24'h0, si = 24'h0;
    logic [7:0]  trim = 8'h40;
    logic [7:0]  tr [4] = '{8'h40, 8'h82, 8'h3C, 8'h68};
    logic [31:0] rq[$];
    logic [49:0] sq[$];
    logic [23:0] hv[$], hi[$];
    logic [49:0] se;
    logic [31:0] re;
    int          errors = 0, checked = 0, wcnt = 0, seed = 61, n;

    always #2 i_clk_sys = ~i_clk_sys;
    pprd_sample_src SRC (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_go      (go),
        .i_slow    (slow),
        .i_v       (sv),
        .i_i       (si),
        .o_ready   (rdy),
        .o_valid   (i_sample_valid),
        .o_v       (i_v_sample),
        .o_i       (i_i_sample)
    );
    pprd_dsp DUT (.*);

    task automatic fail(input string m);
        errors++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic print_verdict;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------
    // scoreboard
    // ----------
    always @(posedge i_clk_sys) begin
        if (rd_d) begin
            re = rq.pop_front();
            checked++;
            if ((o_reg_rdata & re[31:16]) !== re[15:0]) fail("read data");
        end
        rd_d <= i_reg_rd;
        if (o_wave_valid === 1'b1) begin
            wcnt++;
            checked++;
            if (o_wave_data !== (wsrc ? o_irms : o_vrms)) fail("wave data");
        end
        if (o_comp_valid === 1'b1) begin
            se = sq.pop_front();
            checked += int'(se[49]) + int'(se[48]);
            if (se[49] && o_v_comp !== se[47:24]) fail("voltage delay");
            if (se[48] && o_i_comp !== se[23:0]) fail("current delay");
        end
    end
    // ----------
    // drivers
    // ----------
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, m);
        @(negedge i_clk_sys);
        i_reg_wr = w;
        i_reg_rd = !w;
        i_reg_addr = a;
        i_reg_wdata = d;
        if (!w) rq.push_back({m, d});
    endtask
    task automatic quiet;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
    endtask
    task automatic irq(input logic e);
        checked++;
        if (o_meas_irq !== e) fail("irq level");
    endtask
    task automatic sample(input logic [23:0] v, input logic [23:0] c);
        int w;
        int d;
        int k;
        quiet();
        w = 0;
        while (rdy !== 1'b1 && w < 200) begin
            @(posedge i_clk_sys);
            w++;
        end
        if (w >= 200) begin
            fail("source stuck");
            print_verdict();
        end
        hv.push_back(v);
        hi.push_back(c);
        k = hv.size() - 1;
        d = int'($signed(trim)) + 126;
        sq.push_back({k >= d, k >= 190, k >= d ? hv[k - d] : 24'h0,
                      k >= 190 ? hi[k - 190] : 24'h0});
        @(posedge i_clk_sys);
        go = 1'b1;
        sv = v;
        si = c;
        @(posedge i_clk_sys);
        go = 1'b0;
        repeat (3) @(negedge i_clk_sys);
    endtask
    task automatic wave(input logic [1:0] r, input logic en);
        wsrc = r[0];
        bus(1'b1, pprd_pkg::ADDR_WAVE_SEL,
            {11'h0, r, r[0] ? pprd_pkg::WAVE_SRC_IRMS : pprd_pkg::WAVE_SRC_VRMS}, 16'h0);
        bus(1'b1, pprd_pkg::ADDR_IRQ_EN3, {15'h0, en}, 16'h0);
        quiet();
        wcnt = 0;
        repeat (16) begin
            @(negedge i_clk_sys) i_wave_tick = 1'b1;
            @(negedge i_clk_sys) i_wave_tick = 1'b0;
            repeat (2) @(negedge i_clk_sys);
        end
        checked++;
        if (wcnt !== (en ? 16 >> r : 0)) fail("wave rate");
    endtask

    initial begin
        repeat (10) @(negedge i_clk_sys);
        i_rst = 1'b0;
        bus(1'b0, pprd_pkg::ADDR_VPK_THR, 16'hFFFF, 16'hFFFF);
        bus(1'b0, pprd_pkg::ADDR_VMAX, 16'h0000, 16'hFFFF);
        bus(1'b0, pprd_pkg::ADDR_IMAX, 16'h0000, 16'hFFFF);
        bus(1'b0, pprd_pkg::ADDR_TRIM, 16'h0040, 16'h00FF);
        bus(1'b0, 8'h50, 16'h0000, 16'hFFFF);
        bus(1'b1, pprd_pkg::ADDR_IRQ_EN3, 16'h0030, 16'h0);
        bus(1'b1, pprd_pkg::ADDR_VPK_THR, 16'h1000, 16'h0);
        bus(1'b1, pprd_pkg::ADDR_IPK_THR, 16'h28F5, 16'h0);
        quiet();
        // level equal to the threshold must not trip
        sample(24'h100000, 24'h28F5C2);
        bus(1'b0, pprd_pkg::ADDR_IRQ_ST3, 16'h0000, 16'h00FF);
        sample(24'hEFFF00, 24'h000000);
        bus(1'b0, pprd_pkg::ADDR_IRQ_ST3, 16'h0010, 16'h00FF);
        bus(1'b1, pprd_pkg::ADDR_IPK_THR, 16'h0000, 16'h0);
        quiet();
        irq(1'b1);
        sample(24'h000000, 24'hFFFF00);
        bus(1'b0, pprd_pkg::ADDR_IRQ_ST3, 16'h0030, 16'h00FF);
        bus(1'b1, pprd_pkg::ADDR_IRQ_ST3, 16'h0010, 16'h0);
        quiet();
        irq(1'b1);
        bus(1'b1, pprd_pkg::ADDR_IRQ_ST3, 16'h0020, 16'h0);
        bus(1'b1, pprd_pkg::ADDR_IRQ_EN3, 16'h0000, 16'h0);
        quiet();
        irq(1'b0);
        sample(24'hEFFF00, 24'h000000);
        irq(1'b0);
        bus(1'b0, pprd_pkg::ADDR_VMAX_RC, 16'h1001, 16'hFFFF);
        bus(1'b0, pprd_pkg::ADDR_VMAX, 16'h0000, 16'hFFFF);
        bus(1'b0, pprd_pkg::ADDR_IMAX_RC, 16'h28F5, 16'hFFFF);
        bus(1'b0, pprd_pkg::ADDR_IMAX, 16'h0000, 16'hFFFF);
        bus(1'b1, pprd_pkg::ADDR_TRIM, 16'h007F, 16'h0);
        bus(1'b0, pprd_pkg::ADDR_TRIM, 16'h0068, 16'h00FF);
        bus(1'b1, pprd_pkg::ADDR_TRIM, 16'h0080, 16'h0);
        bus(1'b0, pprd_pkg::ADDR_TRIM, 16'h0082, 16'h00FF);
        n = {$random(seed)} % 231;
        bus(1'b1, pprd_pkg::ADDR_TRIM, {8'h00, 8'(n - 126)}, 16'h0);
        bus(1'b0, pprd_pkg::ADDR_TRIM, {8'h00, 8'(n - 126)}, 16'h00FF);
        foreach (tr[j]) begin
            trim = tr[j];
            bus(1'b1, pprd_pkg::ADDR_TRIM, {8'h00, trim}, 16'h0);
            quiet();
            repeat (90) begin
                slow = 1'($random(seed));
                sample(24'($random(seed)), 24'($random(seed)));
            end
        end
        // let the last root finish before the rms and waveform checks
        repeat (40) @(negedge i_clk_sys);
        checked++;
        if ((|o_vrms) !== 1'b1 || (|o_irms) !== 1'b1) fail("rms idle");
        for (int r = 0; r < 4; r++) wave(2'(r), 1'b1);
        wave(2'h0, 1'b0);
        repeat (4) @(negedge i_clk_sys);
        print_verdict();
    end
endmodule // tb
bind pprd_dsp pprd_dsp_monitor MON (.*);
`default_nettype wire
